// ===== hw/qsm_pkg.sv
`default_nettype none
package qsm_pkg;
    // Lane-width modes
    typedef enum logic [1:0] {
        QSM_W_SINGLE = 2'h0,
        QSM_W_DUAL   = 2'h1,
        QSM_W_QUAD   = 2'h2
    } qsm_width_t;

    localparam int unsigned QSM_WORD_BITS  = 32;
    localparam int unsigned QSM_LANES      = 4;
    localparam int unsigned QSM_DIV_BITS   = 8;
    localparam logic [7:0]  QSM_DIV_RESET  = 8'h02;
    localparam logic [5:0]  QSM_CNT_ZERO   = 6'h00;
    localparam logic [5:0]  QSM_BITS_1     = 6'h20;
    localparam logic [5:0]  QSM_BITS_2     = 6'h10;
    localparam logic [5:0]  QSM_BITS_4     = 6'h08;
    localparam logic [5:0]  QSM_BYTE_BEATS = 6'h08;
endpackage
`default_nettype wire

// ===== hw/qsm_lane.sv
`default_nettype none
// One serial channel: mode-3 clock, MSB-first shifting over 1, 2 or 4 lanes
module qsm_lane
    import qsm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_ni,
    input  wire logic [1:0]  width_i,
    input  wire logic        dir_rd_i,
    input  wire logic        byte_i,
    input  wire logic [7:0]  div_i,
    input  wire logic        wr_valid_i,
    output logic             wr_ready_o,
    input  wire logic [31:0] wr_data_i,
    output logic             rd_valid_o,
    input  wire logic        rd_ready_i,
    output logic [31:0]      rd_data_o,
    output logic             busy_o,
    output logic             sck_o,
    output logic [3:0]       lane_o,
    output logic [3:0]       lane_oe_o,
    input  wire logic [3:0]  lane_i
);
    typedef enum logic [1:0] {
        QSM_S_IDLE = 2'h0,
        QSM_S_LOW  = 2'h1,
        QSM_S_HIGH = 2'h2,
        QSM_S_DONE = 2'h3
    } qsm_state_t;

    typedef struct packed {
        qsm_state_t  st;
        logic [7:0]  div;
        logic [7:0]  cnt;
        logic [5:0]  beats;
        logic [31:0] sh;
        logic        sck;
        logic [3:0]  dout;
        logic [3:0]  oe;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  w;
        logic        rd;
        logic        bsz;
    } qsm_lane_t;

    qsm_lane_t s_q, s_d;
    logic [5:0] total;
    logic [3:0] smp;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        s_d   = s_q;
        total = QSM_BITS_1;
        smp   = {3'h0, lane_i[1]};
        case (s_q.w)
            QSM_W_DUAL: begin
                total = QSM_BITS_2;
                smp   = {2'h0, lane_i[1:0]};
            end
            QSM_W_QUAD: begin
                total = QSM_BITS_4;
                smp   = lane_i;
            end
            default: begin
                total = QSM_BITS_1;
                smp   = {3'h0, lane_i[1]};                     // [R7]
            end
        endcase
        if (s_q.bsz)
            total = total >> 2;
        if (rd_valid_o && rd_ready_i)
            s_d.rvalid = 1'b0;
        case (s_q.st)
            QSM_S_IDLE: begin
                s_d.sck = 1'b1;                                 // [R2]
                s_d.oe  = 4'h0;
                s_d.div = div_i;       // Divider latched only here [R19]
                if (wr_valid_i && !s_q.rvalid) begin
                    s_d.w   = width_i;
                    s_d.rd  = dir_rd_i;
                    s_d.bsz = byte_i;
                    s_d.sh  = byte_i ? {wr_data_i[7:0], 24'h0}
                                     : wr_data_i;
                    s_d.beats = QSM_CNT_ZERO;
                    s_d.cnt   = 8'h00;
                    s_d.st    = QSM_S_LOW;
                end
            end
            QSM_S_LOW: begin
                if (s_q.cnt == 8'h00) begin
                    // Falling edge: present next data [R3] [R5]
                    s_d.sck = 1'b0;
                    case (s_q.w)
                        QSM_W_DUAL: s_d.dout = {2'h0, s_q.sh[31:30]};
                        QSM_W_QUAD: s_d.dout = s_q.sh[31:28];
                        default:    s_d.dout = {3'h0, s_q.sh[31]};
                    endcase
                    // Single drives lane 0 only; wide reads float [R18]
                    if (s_q.w == QSM_W_SINGLE)
                        s_d.oe = 4'h1;                           // [R7]
                    else if (s_q.rd)
                        s_d.oe = 4'h0;                           // [R18]
                    else
                        s_d.oe = (s_q.w == QSM_W_QUAD) ? 4'hf : 4'h3;
                end
                s_d.cnt = s_q.cnt + 8'h01;
                if (s_q.cnt >= s_q.div) begin
                    s_d.cnt = 8'h00;
                    s_d.st  = QSM_S_HIGH;
                end
            end
            QSM_S_HIGH: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.sck = 1'b1;                              // [R1]
                    // Rising edge: take in data, MSB first [R4] [R5]
                    case (s_q.w)
                        QSM_W_DUAL: s_d.sh = {s_q.sh[29:0], smp[1:0]};
                        QSM_W_QUAD: s_d.sh = {s_q.sh[27:0], smp};
                        default:    s_d.sh = {s_q.sh[30:0], smp[0]};
                    endcase
                    s_d.beats = s_q.beats + 6'h01;
                end
                s_d.cnt = s_q.cnt + 8'h01;
                if (s_q.cnt >= s_q.div) begin
                    s_d.cnt = 8'h00;
                    // Next count includes this beat, so div 0 ends on time
                    s_d.st  = (s_d.beats == total) ? QSM_S_DONE
                                                   : QSM_S_LOW;
                end
            end
            QSM_S_DONE: begin
                s_d.sck = 1'b1;                                  // [R2]
                s_d.oe  = 4'h0;
                // Single mode always returns data; wide writes do not [R16]
                if (s_q.w == QSM_W_SINGLE || s_q.rd) begin
                    s_d.rvalid = 1'b1;                           // [R15]
                    s_d.rdata  = s_q.bsz ? {24'h0, s_q.sh[7:0]}
                                         : s_q.sh;              // [R17]
                end
                s_d.st = QSM_S_IDLE;
            end
            default: s_d.st = QSM_S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            s_q       <= '0;
            s_q.st    <= QSM_S_IDLE;
            s_q.sck   <= 1'b1;
            s_q.div   <= QSM_DIV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Stalls new words until previous read data is taken [R15] [R16]
    assign wr_ready_o = (s_q.st == QSM_S_IDLE) && !s_q.rvalid;
    assign rd_valid_o = s_q.rvalid;
    assign rd_data_o  = s_q.rdata;
    assign busy_o     = (s_q.st != QSM_S_IDLE);
    assign sck_o      = s_q.sck;                                 // [R8]
    assign lane_o     = s_q.dout;
    assign lane_oe_o  = s_q.oe;

    ////////////////////////////////////////////////////////////////
    sequence idle_s;
        s_q.st == QSM_S_IDLE;
    endsequence

    idle_clk_high_a: assert property (@(posedge clk_i) disable iff (!rst_ni)
        idle_s |-> sck_o) else $error("clock low while idle"); // [R2]
    wide_read_float_a: assert property (@(posedge clk_i)
        disable iff (!rst_ni)
        (s_q.rd && s_q.w != QSM_W_SINGLE) |-> lane_oe_o == 4'h0)
        else $error("lanes driven in wide read"); // [R18]
    single_oe_a: assert property (@(posedge clk_i) disable iff (!rst_ni)
        (busy_o && s_q.w == QSM_W_SINGLE) |-> !lane_oe_o[1])
        else $error("input lane driven in single mode"); // [R7]
    data_on_fall_a: assert property (@(posedge clk_i) disable iff (!rst_ni)
        $changed(lane_o) |-> $fell(sck_o) || !sck_o)
        else $error("data moved while clock high"); // [R3]
    sample_on_rise_a: assert property (@(posedge clk_i)
        disable iff (!rst_ni)
        $rose(sck_o) |-> s_q.beats == $past(s_q.beats) + 6'h01)
        else $error("no sample on rising edge"); // [R4]
    div_stable_a: assert property (@(posedge clk_i) disable iff (!rst_ni)
        busy_o && $past(busy_o) |-> $stable(s_q.div))
        else $error("divider changed mid transfer"); // [R19]
    wide_write_no_rx_a: assert property (@(posedge clk_i)
        disable iff (!rst_ni)
        (s_q.st == QSM_S_DONE && s_q.w != QSM_W_SINGLE && !s_q.rd)
        |=> !rd_valid_o || $past(rd_valid_o))
        else $error("receive flag in wide write"); // [R16]
    done_rx_a: assert property (@(posedge clk_i) disable iff (!rst_ni)
        (s_q.st == QSM_S_DONE && s_q.rd) |=> rd_valid_o ##0 !busy_o)
        else $error("read ended without data"); // [R15]
    msb_first_a: assert property (@(posedge clk_i) disable iff (!rst_ni)
        (s_q.st == QSM_S_LOW && s_q.cnt == 8'h00 && s_q.w == QSM_W_SINGLE)
        |=> lane_o[0] == $past(s_q.sh[31]))
        else $error("not MSB first"); // [R5]
endmodule
`default_nettype wire

// ===== hw/qsm_top.sv
`default_nettype none
// Function
// [R1] Mode 3 only: clock idles high, data phase one.
// [R2] Serial clock high when idle and after the last bit.
// [R3] Outgoing lanes change on serial clock falling edges.
// [R4] Incoming lanes sampled on serial clock rising edges.
// [R5] Every word shifted MSB first in all widths.
// [R6] Single, dual and quad widths selected by a control input.
// [R7] Single: lane 0 out, lane 1 in; wider modes both bidirectional.
// [R8] Serial clock comes from the internal clock; always master.
// [R9] One or more independent channels with own lanes and control.
// [R10] Data word is 32 bits; byte transfers also supported.
// [R11] Slave select driven outside this block, per slave, active low.
// [R12] Outside party asserts select a wait before first falling edge.
// [R13] Outside party holds select a wait after last rising edge.
// [R14] Outside party runs a 1 ms timeout tick for DMA transfers.
// [R15] Transmit-empty and receive-full requests raised to the host.
// [R16] Wide writes use transmit-empty only; wide reads receive-full only. Wide reads here also need transmit-empty to start.
// [R17] Bytes sent in supplied order and stored in arrival order.
// [R18] Wide reads float the lanes; wide writes drive them.
// [R19] Bit-rate divider sets clock rate; changes only when idle.
module qsm_top
    import qsm_pkg::*;
#(
    parameter int unsigned CHANNELS = 1
) (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic [2*CHANNELS-1:0] width_i,
    input  wire logic [CHANNELS-1:0]   dir_rd_i,
    input  wire logic [CHANNELS-1:0]   byte_i,
    input  wire logic [8*CHANNELS-1:0] div_i,
    input  wire logic [CHANNELS-1:0]   wr_valid_i,
    output logic      [CHANNELS-1:0]   tx_empty_o,
    input  wire logic [32*CHANNELS-1:0] wr_data_i,
    output logic      [CHANNELS-1:0]   rx_full_o,
    input  wire logic [CHANNELS-1:0]   rd_ready_i,
    output logic      [32*CHANNELS-1:0] rd_data_o,
    output logic      [CHANNELS-1:0]   busy_o,
    output logic      [CHANNELS-1:0]   serial_clock_out_o,
    output logic      [4*CHANNELS-1:0] data_lane_o,
    output logic      [4*CHANNELS-1:0] data_lane_oe_o,
    input  wire logic [4*CHANNELS-1:0] data_lane_i
);
    logic [1:0] rst_sync_q;
    logic [4*CHANNELS-1:0] lane_m_q;
    logic [4*CHANNELS-1:0] lane_s_q;

    // Reset released through two stages
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // Pins from the slave cross two flops before use
    always_ff @(posedge clk_i or negedge rst_sync_q[1]) begin
        if (!rst_sync_q[1]) begin
            lane_m_q <= '0;
            lane_s_q <= '0;
        end else begin
            lane_m_q <= data_lane_i;
            lane_s_q <= lane_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Independent engines per channel [R9]
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        qsm_lane u_lane (
            .clk_i      (clk_i),
            .rst_ni     (rst_sync_q[1]),
            .width_i    (width_i[2*c +: 2]),                     // [R6]
            .dir_rd_i   (dir_rd_i[c]),
            .byte_i     (byte_i[c]),                             // [R10]
            .div_i      (div_i[8*c +: 8]),                       // [R19]
            .wr_valid_i (wr_valid_i[c]),
            .wr_ready_o (tx_empty_o[c]),                         // [R15]
            .wr_data_i  (wr_data_i[32*c +: 32]),
            .rd_valid_o (rx_full_o[c]),
            .rd_ready_i (rd_ready_i[c]),
            .rd_data_o  (rd_data_o[32*c +: 32]),
            .busy_o     (busy_o[c]),
            .sck_o      (serial_clock_out_o[c]),
            .lane_o     (data_lane_o[4*c +: 4]),
            .lane_oe_o  (data_lane_oe_o[4*c +: 4]),
            .lane_i     (lane_s_q[4*c +: 4])
        );
    end
endmodule
`default_nettype wire

// ===== bench/qsm_slave_model.sv
`default_nettype none
// Serial memory seen from its pins: mode 3, MSB first, 1/2/4 lanes
module qsm_slave_model
    import qsm_pkg::*;
(
    input  wire logic        sel_n_i,
    input  wire logic        sck_i,
    input  wire logic [1:0]  width_i,
    input  wire logic        rd_i,
    input  wire logic [31:0] word_i,
    input  wire logic [3:0]  lane_i,
    output logic      [3:0]  lane_o,
    output logic      [3:0]  oe_o,
    output logic      [31:0] got_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sh;
    int          n;
    initial begin
        lane_o = 4'h0;
        oe_o = 4'h0;
        got_o = 32'h0;
    end
    always @(negedge sel_n_i) begin
        sh = word_i;
        got_o = 32'h0;
    end
    // Drives only while selected; released lanes fall to the pull-ups
    always @(negedge sck_i) if (!sel_n_i) begin
        n = (width_i == QSM_W_QUAD) ? 4 : (width_i == QSM_W_DUAL) ? 2 : 1;
        if (n == 1) begin
            lane_o = {2'h0, sh[31], 1'b0};
            oe_o = 4'h2;
        end else begin
            lane_o = sh[31:28] >> (4 - n);
            oe_o = rd_i ? 4'((1 << n) - 1) : 4'h0;
        end
        sh = sh << n;
    end
    always @(posedge sck_i) if (!sel_n_i) begin
        n = (width_i == QSM_W_QUAD) ? 4 : (width_i == QSM_W_DUAL) ? 2 : 1;
        got_o = (got_o << n) | {28'h0, lane_i & 4'((1 << n) - 1)};
    end
    always @(posedge sel_n_i) begin
        oe_o = 4'h0;
        lane_o = ~lane_o;
    end
endmodule
`default_nettype wire

// ===== bench/quad_spi_single_master_tb_top.sv
`default_nettype none
module quad_spi_single_master_tb_top
    import qsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, resetn_i, dir_rd, byte_m, wr_valid, rd_ready;
    logic        tx_empty, rx_full, busy, sck, sel_n, p_sck;
    logic [1:0]  width;
    logic [7:0]  div;
    logic [31:0] wr_data, rd_data, s_word, s_got;
    logic [3:0]  d_o, d_oe, s_o, s_oe, lane_w, p_oe, p_lane, oe_seen;
    int          n_errors, samples_checked, falls, low_cnt, low_len;
    // Pull-ups hold every undriven lane high
    assign lane_w = (d_oe & d_o) | (~d_oe & s_oe & s_o) | (~d_oe & ~s_oe);
    qsm_top #(.CHANNELS(1)) qsm_top_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .width_i(width),
        .dir_rd_i(dir_rd), .byte_i(byte_m), .div_i(div),
        .wr_valid_i(wr_valid), .tx_empty_o(tx_empty), .wr_data_i(wr_data),
        .rx_full_o(rx_full), .rd_ready_i(rd_ready), .rd_data_o(rd_data),
        .busy_o(busy), .serial_clock_out_o(sck), .data_lane_o(d_o),
        .data_lane_oe_o(d_oe), .data_lane_i(lane_w));
    qsm_slave_model qsm_slave_model_inst (
        .sel_n_i(sel_n), .sck_i(sck), .width_i(width), .rd_i(dir_rd),
        .word_i(s_word), .lane_i(lane_w), .lane_o(s_o), .oe_o(s_oe),
        .got_o(s_got));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Bounded wait flags and aborts a stalled transfer
    task automatic give_up(int k, int lim);
        if (k >= lim) begin
            n_errors++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (resetn_i) begin
            if (busy !== 1'b1) check("sck_idle", 32'(sck), 32'h1);
            check("lane_edge", 32'(|(d_oe & p_oe & (d_o ^ p_lane)) &&
                  !(p_sck && !sck)), 32'h0);
            if (p_sck && !sck) begin
                falls++;
                low_cnt = 1;
            end else if (!sck) low_cnt++;
            if (!p_sck && sck) low_len = low_cnt;
            oe_seen = oe_seen | d_oe;
        end
        p_sck = sck;
        p_oe = d_oe;
        p_lane = d_o;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(logic [1:0] w, logic rd, logic bm, logic [7:0] dv,
                        logic [31:0] wd, logic [31:0] sd, logic [3:0] oe_x);
        int n;
        int k;
        logic wr_wide;
        n = (w == QSM_W_QUAD) ? 4 : (w == QSM_W_DUAL) ? 2 : 1;
        wr_wide = (w != QSM_W_SINGLE) && !rd;
        @(negedge clk_i);
        {width, dir_rd, byte_m, div} = {w, rd, bm, dv};
        {wr_data, s_word} = {wd, sd};
        sel_n = 1'b0;
        repeat (3) @(negedge clk_i);
        falls = 0;
        oe_seen = 4'h0;
        wr_valid = 1'b1;
        for (k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clk_i);
        give_up(k, 20);
        wr_valid = 1'b0;
        div = 8'h07; // Busy: must not take effect
        for (k = 0; k < 2000 && busy === 1'b1; k++) @(negedge clk_i);
        give_up(k, 2000);
        if (wr_wide) begin
            repeat (4) @(negedge clk_i);
            check("rx_full", 32'(rx_full), 32'h0);
        end else begin
            for (k = 0; k < 10 && rx_full !== 1'b1; k++) @(negedge clk_i);
            give_up(k, 10);
            check("tx_empty", 32'(tx_empty), 32'h0);
            check("rd_data", rd_data,
                  bm ? {24'h0, sd[31:24]} : sd);
            rd_ready = 1'b1;
            @(negedge clk_i);
            rd_ready = 1'b0;
        end
        if (!(rd && w != QSM_W_SINGLE))
            check("slave_got", s_got,
                  bm ? {24'h0, wd[7:0]} : wd);
        check("beats", 32'(falls), 32'((bm ? 8 : 32) / n));
        check("half_period", 32'(low_len), 32'(dv) + 32'h1);
        check("lane_drive", 32'(oe_seen), 32'(oe_x));
        check("tx_empty_idle", 32'(tx_empty), 32'h1);
        repeat (2) @(negedge clk_i);
        sel_n = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("sck_rst", 32'(sck), 32'h1);
        check("oe_rst", 32'(d_oe), 32'h0);
        check("rx_rst", 32'(rx_full), 32'h0);
        check("tx_rst", 32'(tx_empty), 32'h1);
        $display("test reset done");
    endtask
    task automatic t_single();
        xfer(QSM_W_SINGLE, 1'b0, 1'b0, 8'h03, 32'ha5c30f81, 32'h3c96e01b,
             4'h1);
        xfer(QSM_W_SINGLE, 1'b1, 1'b1, 8'h05, 32'h000000d2, 32'h69ffffff,
             4'h1);
        $display("test single done");
    endtask
    task automatic t_dual();
        xfer(QSM_W_DUAL, 1'b0, 1'b0, 8'h03, 32'h1e2d4b87, 32'h0, 4'h3);
        xfer(QSM_W_DUAL, 1'b1, 1'b0, 8'h04, 32'h0, 32'hc6390ff0, 4'h0);
        // Fastest divider, byte write: beat count must end exactly
        xfer(QSM_W_DUAL, 1'b0, 1'b1, 8'h00, 32'h0000004b, 32'h0, 4'h3);
        $display("test dual done");
    endtask
    task automatic t_quad();
        xfer(QSM_W_QUAD, 1'b0, 1'b0, 8'h03, 32'h80f1e2d7, 32'h0, 4'hf);
        xfer(QSM_W_QUAD, 1'b1, 1'b1, 8'h03, 32'h0, 32'h5a000000, 4'h0);
        xfer(QSM_W_QUAD, 1'b1, 1'b0, 8'h05, 32'h0, 32'h0123abcd, 4'h0);
        $display("test quad done");
    endtask
    initial begin
        {resetn_i, dir_rd, byte_m, wr_valid, rd_ready, sel_n} = 6'h01;
        {width, div, wr_data, s_word} = '0;
        {n_errors, samples_checked, falls, low_cnt, low_len} = '0;
        {p_sck, p_oe, p_lane, oe_seen} = '0;
        repeat (8) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_reset();
        t_single();
        t_dual();
        t_quad();
        end_sim();
    end
endmodule
`default_nettype wire
